// ### bbt_defines.svh
/*
 * Offsets, field positions, reset values and fixed sizes of the window
 * setup and lookup translation block.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef BBT_DEFINES_SVH
`define BBT_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the cfg and rom ports)
// ----------------------------------------------------------------
`define BBT_OFS_LUT_IDX 8'h24
`define BBT_OFS_LUT_DATA 8'h28
`define BBT_OFS_CTRL 8'h40
`define BBT_OFS_EVT_LO 8'h48
`define BBT_OFS_EVT_HI 8'h4c
`define BBT_OFS_MSK_LO 8'h50
`define BBT_OFS_MSK_HI 8'h54
`define BBT_OFS_SETUP 8'h80
`define BBT_OFS_BAR 8'ha0
`define BBT_OFS_XLAT 8'hc0
`define BBT_GRP_MASK 8'he0
`define BBT_IDX_MSB 4
`define BBT_IDX_LSB 2
`define BBT_IDX_HI 3'h6
`define BBT_IDX_U2 3'h7

// ----------------------------------------------------------------
// windows
// ----------------------------------------------------------------
`define BBT_NWIN 6
`define BBT_NUM_PRI 4
`define BBT_WIN_DS3 3

// ----------------------------------------------------------------
// setup and bar fields
// ----------------------------------------------------------------
`define BBT_SET_IO_BIT 0
`define BBT_SET_PF_BIT 3
`define BBT_SET_EN_BIT 31
`define BBT_SET_TYPE_MSB 2
`define BBT_SET_TYPE_LSB 1
`define BBT_TYPE_64 2'h2
`define BBT_MEM_MASK 32'hfffffff0
`define BBT_IO_MASK 32'hfffffffc
`define BBT_MEM_TYPE 32'h0000000f
`define BBT_IO_TYPE 32'h00000001
`define BBT_CSR_MASK 32'hfffff000
`define BBT_CSR_SIZE_BIT 12
`define BBT_SETUP_RST 32'h00000000
`define BBT_BAR_RST 32'h00000000

// ----------------------------------------------------------------
// chip control and page table
// ----------------------------------------------------------------
`define BBT_CTRL_PG_MSB 3
`define BBT_CTRL_PG_LSB 0
`define BBT_CTRL_LUT_EN 4
`define BBT_CTRL_MAM 5
`define BBT_CTRL_PW_SERR_DIS 6
`define BBT_CTRL_SERR_EN 7
`define BBT_CTRL_RST 32'h00000000
`define BBT_PG_MAX 4'he
`define BBT_PG_SHIFT0 5'h08
`define BBT_IDX_BITS 5'h06
`define BBT_ENT_VALID 0
`define BBT_ENT_PF 1
`define BBT_DW_LOW 32'h00000003
`define BBT_EVT_RST 64'h0000000000000000
`define BBT_MSK_RST 64'hffffffffffffffff

`endif

// ### bbt_pkg.sv
/*
 * Types shared by the translation block and its users.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bbt_pkg;

	// ----------------------------------------------------------------
	// outcome of a secondary decode
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BBT_RES_NONE = 3'h0,
		BBT_RES_OK = 3'h1,
		BBT_RES_WR_ABORT = 3'h2,
		BBT_RES_RD_ONES = 3'h3,
		BBT_RES_TABORT = 3'h4
	} bbt_res_e;

endpackage : bbt_pkg

// ### bbt_win_dec.sv
/*
 * One direct-translation window: size mask, enable, range match,
 * base substitution and bar read-back.
 * Assumes setup, bar and translated base come from registers.
 */
`timescale 1ns/100ps
`include "bbt_defines.svh"

module bbt_win_dec #(
	parameter bit IO_CAPABLE = 1'b0,
	parameter bit CSR_WIN = 1'b0
) (
	input wire logic [31:0] setup,
	input wire logic [31:0] bar,
	input wire logic [31:0] xlat,
	input wire logic [31:0] addr,
	input wire logic is_io,
	output logic enabled,
	output logic hit,
	output logic csr_hit,
	output logic [31:0] xaddr,
	output logic [31:0] bar_rd
);
	logic io_sel;
	logic fwd_en;
	logic in_range;
	logic [31:0] mask;

	always_comb begin
		io_sel = IO_CAPABLE && setup[`BBT_SET_IO_BIT];
		if (CSR_WIN) begin
			mask = setup[`BBT_SET_EN_BIT] ? (setup & `BBT_CSR_MASK) : `BBT_CSR_MASK;
		end else if (io_sel) begin
			mask = setup & `BBT_IO_MASK;
		end else begin
			mask = setup & `BBT_MEM_MASK;
		end
		enabled = CSR_WIN || setup[`BBT_SET_EN_BIT];
		fwd_en = !CSR_WIN || (setup[`BBT_SET_EN_BIT] && !setup[`BBT_CSR_SIZE_BIT]);
		in_range = enabled && (is_io == io_sel) && ((addr & mask) == (bar & mask));
		csr_hit = CSR_WIN && in_range && ((addr & `BBT_CSR_MASK) == (bar & mask));
		hit = in_range && fwd_en && !csr_hit;
		xaddr = (xlat & mask) | (addr & ~mask);
		bar_rd = (bar & mask) | (setup & (io_sel ? `BBT_IO_TYPE : `BBT_MEM_TYPE));
	end

endmodule : bbt_win_dec

// ### bbt_bridge_xlat.sv
/*
 * Window setup, bar decode and address translation for both buses,
 * with the 64-page upstream lookup table and its page events.
 * Assumes bus interface logic on the same clock presents decodes and
 * register accesses, and the serial rom loader writes setup registers.
 */
`timescale 1ns/100ps
`include "bbt_defines.svh"

// Behaviour
// - Combined csr window always maps csrs low 4KB; 4KB request stops forwarding.
// - Third downstream memory window becomes 64-bit when type field is 10b.
// - Setup registers load from serial rom and accept secondary side writes.
// - Setup bit zero picks memory (0) or io (1) for dual windows.
// - Setup bits two and one set the memory type the window reports.
// - Setup one makes base bit writable, zero makes it read zero.
// - Top writable setup bit zero disables window; the csr window still maps its 4KB csr page.
// - Each direct window is programmable prefetchable and reports that attribute; lookup pages take it from the entry.
// - Direct substitution everywhere but lookup window; csr page never forwarded.
// - Writable base bits replaced by translated base, offset passes unchanged.
// - Every direct window has its own translated base register.
// - Lookup window holds 64 pages, 256B to 4MB each, and can be disabled.
// - Six bits above page offset index table; entry replaces base and index.
// - Page table on chip, reached through index and data ports 24h, 28h.
// - Transfer to page last dword sets page event; mask gates interrupt.
// - Entry upper bits give translated base; low bits hold valid and prefetch.
// - Write to invalid page aborts, discards data, may raise system error.
// - Read of invalid page returns all ones, or target abort by mode.
// - Reset leaves page table untouched; processor must initialise it first.
// - Claim only addresses inside an enabled window of that bus.
module bbt_bridge_xlat #(
	parameter int PAGES = 64
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic rom_wr,
	input wire logic [7:0] rom_addr,
	input wire logic [31:0] rom_data,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic cfg_sec,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic pri_valid,
	input wire logic pri_io,
	input wire logic [31:0] pri_addr,
	output logic pri_claim,
	output logic pri_csr,
	output logic [1:0] pri_win,
	output logic pri_prefetch,
	output logic [31:0] pri_xaddr,
	input wire logic sec_valid,
	input wire logic sec_io,
	input wire logic sec_write,
	input wire logic sec_xfer,
	input wire logic [31:0] sec_addr,
	output logic sec_claim,
	output logic sec_lut,
	output logic [1:0] sec_win,
	output logic sec_prefetch,
	output logic [31:0] sec_xaddr,
	output bbt_pkg::bbt_res_e sec_result,
	output logic sec_serr_n,
	output logic sec_inta_n
);
	if (PAGES != 64) begin : g_chk
		$error("page table must hold 64 entries");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0] setup_reg [`BBT_NWIN];
	logic [31:0] setup_next [`BBT_NWIN];
	logic [31:0] bar_reg [`BBT_NWIN];
	logic [31:0] bar_next [`BBT_NWIN];
	logic [31:0] xlat_reg [`BBT_NWIN];
	logic [31:0] xlat_next [`BBT_NWIN];
	logic [31:0] setup_hi_reg, setup_hi_next, bar_hi_reg, bar_hi_next;
	logic [31:0] bar_u2_reg, bar_u2_next, ctrl_reg, ctrl_next;
	logic [5:0] lut_idx_reg, lut_idx_next;
	logic [63:0] event_reg, event_next, evmask_reg, evmask_next, evt_set, evt_clr;
	logic inta_n_reg, inta_n_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] lut_mem [PAGES];
	logic [`BBT_NWIN-1:0] dec_hit, dec_csr, dec_en;
	logic [31:0] dec_xaddr [`BBT_NWIN];
	logic [31:0] dec_bar_rd [`BBT_NWIN];
	logic s_wr;
	logic [7:0] s_addr;
	logic [31:0] s_data;
	logic [2:0] c_idx, s_idx;
	logic is_64;
	logic [3:0] pg_eff;
	logic [4:0] shift;
	logic [31:0] page_mask, win_mask, sh_addr, entry;
	logic [5:0] lidx;
	logic u2_hit, last_dw;

	// ----------------------------------------------------------------
	// per-window decoders
	// ----------------------------------------------------------------
	for (genvar g = 0; g < `BBT_NWIN; g++) begin : g_win
		bbt_win_dec #(
			.IO_CAPABLE(g == 1 || g == 4),
			.CSR_WIN(g == 0)
		) u_dec (
			.setup(setup_reg[g]),
			.bar(bar_reg[g]),
			.xlat(xlat_reg[g]),
			.addr((g < `BBT_NUM_PRI) ? pri_addr : sec_addr),
			.is_io((g < `BBT_NUM_PRI) ? pri_io : sec_io),
			.enabled(dec_en[g]),
			.hit(dec_hit[g]),
			.csr_hit(dec_csr[g]),
			.xaddr(dec_xaddr[g]),
			.bar_rd(dec_bar_rd[g])
		);
	end

	// ----------------------------------------------------------------
	// lookup window decode
	// ----------------------------------------------------------------
	always_comb begin
		pg_eff = (ctrl_reg[`BBT_CTRL_PG_MSB:`BBT_CTRL_PG_LSB] > `BBT_PG_MAX) ? `BBT_PG_MAX :
			ctrl_reg[`BBT_CTRL_PG_MSB:`BBT_CTRL_PG_LSB];
		shift = 5'(pg_eff) + `BBT_PG_SHIFT0;
		page_mask = (32'h1 << shift) - 32'h1;
		win_mask = ~((32'h1 << (shift + `BBT_IDX_BITS)) - 32'h1);
		sh_addr = sec_addr >> shift;
		lidx = sh_addr[5:0];
		entry = lut_mem[lidx];
		u2_hit = ctrl_reg[`BBT_CTRL_LUT_EN] && !sec_io &&
			((sec_addr & win_mask) == (bar_u2_reg & win_mask));
		last_dw = ((sec_addr | `BBT_DW_LOW) & page_mask) == page_mask;
		is_64 = setup_reg[`BBT_WIN_DS3][`BBT_SET_TYPE_MSB:`BBT_SET_TYPE_LSB] == `BBT_TYPE_64;
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_comb begin
		s_wr = rom_wr || (cfg_wr && cfg_sec);
		s_addr = rom_wr ? rom_addr : cfg_addr;
		s_data = rom_wr ? rom_data : cfg_wdata;
		s_idx = s_addr[`BBT_IDX_MSB:`BBT_IDX_LSB];
		c_idx = cfg_addr[`BBT_IDX_MSB:`BBT_IDX_LSB];
		setup_next = setup_reg;
		bar_next = bar_reg;
		xlat_next = xlat_reg;
		setup_hi_next = setup_hi_reg;
		bar_hi_next = bar_hi_reg;
		bar_u2_next = bar_u2_reg;
		ctrl_next = ctrl_reg;
		lut_idx_next = lut_idx_reg;
		evmask_next = evmask_reg;
		evt_clr = '0;
		for (int i = 0; i < `BBT_NWIN; i++) begin
			if (s_wr && (s_addr & `BBT_GRP_MASK) == `BBT_OFS_SETUP && s_idx == 3'(i)) begin
				setup_next[i] = s_data;
			end
			// downstream bars belong to primary space, upstream to secondary
			if (cfg_wr && (cfg_addr & `BBT_GRP_MASK) == `BBT_OFS_BAR && c_idx == 3'(i) &&
					(cfg_sec == (i >= `BBT_NUM_PRI))) begin
				bar_next[i] = cfg_wdata;
			end
			if (cfg_wr && (cfg_addr & `BBT_GRP_MASK) == `BBT_OFS_XLAT && c_idx == 3'(i)) begin
				xlat_next[i] = cfg_wdata;
			end
		end
		if (s_wr && (s_addr & `BBT_GRP_MASK) == `BBT_OFS_SETUP && s_idx == `BBT_IDX_HI) begin
			setup_hi_next = s_data;
		end
		if (cfg_wr && (cfg_addr & `BBT_GRP_MASK) == `BBT_OFS_BAR) begin
			// upper half only for 64-bit type
			if (c_idx == `BBT_IDX_HI && !cfg_sec) begin
				bar_hi_next = is_64 ? (cfg_wdata & setup_hi_reg) : '0;
			end
			if (c_idx == `BBT_IDX_U2 && cfg_sec) begin
				bar_u2_next = cfg_wdata;
			end
		end
		if (cfg_wr) begin
			case (cfg_addr)
				`BBT_OFS_CTRL: begin
					ctrl_next = cfg_wdata;
				end
				`BBT_OFS_LUT_IDX: begin
					lut_idx_next = cfg_wdata[5:0];
				end
				`BBT_OFS_EVT_LO: begin
					evt_clr[31:0] = cfg_wdata;
				end
				`BBT_OFS_EVT_HI: begin
					evt_clr[63:32] = cfg_wdata;
				end
				`BBT_OFS_MSK_LO: begin
					evmask_next[31:0] = cfg_wdata;
				end
				`BBT_OFS_MSK_HI: begin
					evmask_next[63:32] = cfg_wdata;
				end
				default: begin
				end
			endcase
		end
		evt_set = (sec_valid && sec_xfer && u2_hit && entry[`BBT_ENT_VALID] && last_dw) ?
			(64'h1 << lidx) : '0;
		event_next = (event_reg & ~evt_clr) | evt_set;
		inta_n_next = !(|(event_next & ~evmask_next));
		rvalid_next = cfg_rd;
		rdata_next = '0;
		if (cfg_rd) begin
			case (cfg_addr & `BBT_GRP_MASK)
				`BBT_OFS_SETUP: begin
					rdata_next = (c_idx < 3'(`BBT_NWIN)) ? setup_reg[c_idx] :
						(c_idx == `BBT_IDX_HI) ? setup_hi_reg : '0;
				end
				`BBT_OFS_BAR: begin
					rdata_next = (c_idx < 3'(`BBT_NWIN)) ? dec_bar_rd[c_idx] :
						(c_idx == `BBT_IDX_HI) ? bar_hi_reg : (bar_u2_reg & win_mask);
				end
				`BBT_OFS_XLAT: begin
					rdata_next = (c_idx < 3'(`BBT_NWIN)) ? xlat_reg[c_idx] : '0;
				end
				default: begin
					case (cfg_addr)
						`BBT_OFS_LUT_IDX: rdata_next = 32'(lut_idx_reg);
						`BBT_OFS_LUT_DATA: rdata_next = lut_mem[lut_idx_reg];
						`BBT_OFS_CTRL: rdata_next = ctrl_reg;
						`BBT_OFS_EVT_LO: rdata_next = event_reg[31:0];
						`BBT_OFS_EVT_HI: rdata_next = event_reg[63:32];
						`BBT_OFS_MSK_LO: rdata_next = evmask_reg[31:0];
						`BBT_OFS_MSK_HI: rdata_next = evmask_reg[63:32];
						default: rdata_next = '0;
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `BBT_NWIN; i++) begin
				setup_reg[i] <= `BBT_SETUP_RST;
				bar_reg[i] <= `BBT_BAR_RST;
				xlat_reg[i] <= `BBT_BAR_RST;
			end
			setup_hi_reg <= `BBT_SETUP_RST;
			bar_hi_reg <= `BBT_BAR_RST;
			bar_u2_reg <= `BBT_BAR_RST;
			ctrl_reg <= `BBT_CTRL_RST;
			lut_idx_reg <= '0;
			event_reg <= `BBT_EVT_RST;
			evmask_reg <= `BBT_MSK_RST;
			inta_n_reg <= 1'b1;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else if (ce) begin
			setup_reg <= setup_next;
			bar_reg <= bar_next;
			xlat_reg <= xlat_next;
			setup_hi_reg <= setup_hi_next;
			bar_hi_reg <= bar_hi_next;
			bar_u2_reg <= bar_u2_next;
			ctrl_reg <= ctrl_next;
			lut_idx_reg <= lut_idx_next;
			event_reg <= event_next;
			evmask_reg <= evmask_next;
			inta_n_reg <= inta_n_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	always_ff @(posedge clock) begin
		if (ce && cfg_wr && cfg_addr == `BBT_OFS_LUT_DATA) begin
			lut_mem[lut_idx_reg] <= cfg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// decode outputs
	// ----------------------------------------------------------------
	logic pri_claim_reg, pri_claim_next, pri_csr_reg, pri_csr_next, pri_pf_reg, pri_pf_next;
	logic [1:0] pri_win_reg, pri_win_next, sec_win_reg, sec_win_next;
	logic [31:0] pri_xaddr_reg, pri_xaddr_next, sec_xaddr_reg, sec_xaddr_next;
	logic sec_claim_reg, sec_claim_next, sec_lut_reg, sec_lut_next, sec_pf_reg, sec_pf_next;
	logic serr_n_reg, serr_n_next;
	bbt_pkg::bbt_res_e res_reg, res_next;

	always_comb begin
		pri_win_next = '0;
		pri_xaddr_next = '0;
		pri_pf_next = 1'b0;
		pri_csr_next = pri_valid && dec_csr[0];
		pri_claim_next = pri_valid && (dec_csr[0] || |dec_hit[`BBT_NUM_PRI-1:0]);
		for (int i = `BBT_NUM_PRI - 1; i >= 0; i--) begin
			if (dec_hit[i]) begin
				pri_win_next = 2'(i);
				pri_xaddr_next = dec_xaddr[i];
				pri_pf_next = setup_reg[i][`BBT_SET_PF_BIT];
			end
		end
		sec_win_next = '0;
		sec_xaddr_next = '0;
		sec_pf_next = 1'b0;
		sec_lut_next = 1'b0;
		res_next = bbt_pkg::BBT_RES_NONE;
		serr_n_next = 1'b1;
		if (sec_valid && |dec_hit[`BBT_NWIN-1:`BBT_NUM_PRI]) begin
			sec_win_next = dec_hit[`BBT_NUM_PRI] ? 2'h0 : 2'h1;
			sec_xaddr_next = dec_hit[`BBT_NUM_PRI] ? dec_xaddr[`BBT_NUM_PRI] :
				dec_xaddr[`BBT_NUM_PRI+1];
			sec_pf_next = dec_hit[`BBT_NUM_PRI] ? setup_reg[`BBT_NUM_PRI][`BBT_SET_PF_BIT] :
				setup_reg[`BBT_NUM_PRI+1][`BBT_SET_PF_BIT];
			res_next = bbt_pkg::BBT_RES_OK;
		end else if (sec_valid && u2_hit) begin
			sec_lut_next = 1'b1;
			// entry base above page offset, offset bits from the address
			sec_xaddr_next = (entry & ~page_mask) | (sec_addr & page_mask);
			sec_pf_next = entry[`BBT_ENT_PF];
			if (entry[`BBT_ENT_VALID]) begin
				res_next = bbt_pkg::BBT_RES_OK;
			end else if (sec_write) begin
				// invalid write aborts and may raise serr
				res_next = bbt_pkg::BBT_RES_WR_ABORT;
				serr_n_next = !(ctrl_reg[`BBT_CTRL_SERR_EN] && !ctrl_reg[`BBT_CTRL_PW_SERR_DIS]);
			end else begin
				res_next = ctrl_reg[`BBT_CTRL_MAM] ? bbt_pkg::BBT_RES_TABORT :
					bbt_pkg::BBT_RES_RD_ONES;
			end
		end
		sec_claim_next = res_next != bbt_pkg::BBT_RES_NONE;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pri_claim_reg <= 1'b0;
			pri_csr_reg <= 1'b0;
			pri_win_reg <= '0;
			pri_pf_reg <= 1'b0;
			pri_xaddr_reg <= '0;
			sec_claim_reg <= 1'b0;
			sec_lut_reg <= 1'b0;
			sec_win_reg <= '0;
			sec_pf_reg <= 1'b0;
			sec_xaddr_reg <= '0;
			res_reg <= bbt_pkg::BBT_RES_NONE;
			serr_n_reg <= 1'b1;
		end else if (ce) begin
			pri_claim_reg <= pri_claim_next;
			pri_csr_reg <= pri_csr_next;
			pri_win_reg <= pri_win_next;
			pri_pf_reg <= pri_pf_next;
			pri_xaddr_reg <= pri_xaddr_next;
			sec_claim_reg <= sec_claim_next;
			sec_lut_reg <= sec_lut_next;
			sec_win_reg <= sec_win_next;
			sec_pf_reg <= sec_pf_next;
			sec_xaddr_reg <= sec_xaddr_next;
			res_reg <= res_next;
			serr_n_reg <= serr_n_next;
		end
	end

	assign cfg_rdata = rdata_reg;
	assign cfg_rvalid = rvalid_reg;
	assign pri_claim = pri_claim_reg;
	assign pri_csr = pri_csr_reg;
	assign pri_win = pri_win_reg;
	assign pri_prefetch = pri_pf_reg;
	assign pri_xaddr = pri_xaddr_reg;
	assign sec_claim = sec_claim_reg;
	assign sec_lut = sec_lut_reg;
	assign sec_win = sec_win_reg;
	assign sec_prefetch = sec_pf_reg;
	assign sec_xaddr = sec_xaddr_reg;
	assign sec_result = res_reg;
	assign sec_serr_n = serr_n_reg;
	assign sec_inta_n = inta_n_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	setup_pri_locked_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && !rom_wr && cfg_wr && !cfg_sec && (cfg_addr & `BBT_GRP_MASK) == `BBT_OFS_SETUP
		|=> $stable(setup_reg[0]) && $stable(setup_reg[1]))
		else $error("setup changed by primary write");
	win_disabled_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && pri_valid && !setup_reg[2][`BBT_SET_EN_BIT] && !dec_hit[1] && !dec_hit[3]
		&& !dec_csr[0] && !dec_hit[0] |=> !pri_claim) else $error("disabled window claimed");
	bar_ro_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		((dec_bar_rd[2] & ~setup_reg[2]) & `BBT_MEM_MASK) == '0)
		else $error("masked bar bit reads one");
	csr_no_fwd_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && pri_valid && dec_csr[0] |=> pri_claim && pri_csr && pri_win == 2'h0)
		else $error("csr page access not claimed as csr");
	direct_offset_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && pri_valid && !pri_io && dec_hit[1] && !dec_hit[0] |=>
		((pri_xaddr ^ $past(pri_addr)) & ~($past(setup_reg[1]) & `BBT_MEM_MASK)) == '0)
		else $error("direct offset altered");
	lut_offset_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && sec_valid && u2_hit && !(|dec_hit[`BBT_NWIN-1:`BBT_NUM_PRI]) |=>
		sec_lut && ((sec_xaddr ^ $past(sec_addr)) & $past(page_mask)) == '0)
		else $error("lookup offset altered");
	event_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && !(cfg_wr && (cfg_addr == `BBT_OFS_EVT_LO || cfg_addr == `BBT_OFS_EVT_HI))
		|=> (event_reg & $past(event_reg)) == $past(event_reg))
		else $error("page event lost without clear");
	inta_raise_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && |(evt_set & ~evmask_next) |=> !sec_inta_n [*2] or (!sec_inta_n ##1 !ce)
		or (!sec_inta_n ##1 cfg_wr)) else $error("unmasked last dword event not signalled");
	invalid_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && sec_valid && u2_hit && !(|dec_hit[`BBT_NWIN-1:`BBT_NUM_PRI]) &&
		!entry[`BBT_ENT_VALID] && sec_write |=> sec_result == bbt_pkg::BBT_RES_WR_ABORT &&
		sec_serr_n == !($past(ctrl_reg[`BBT_CTRL_SERR_EN]) &&
		!$past(ctrl_reg[`BBT_CTRL_PW_SERR_DIS]))) else $error("invalid write not aborted");
	invalid_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && sec_valid && u2_hit && !(|dec_hit[`BBT_NWIN-1:`BBT_NUM_PRI]) &&
		!entry[`BBT_ENT_VALID] && !sec_write |=> sec_result == ($past(ctrl_reg[`BBT_CTRL_MAM]) ?
		bbt_pkg::BBT_RES_TABORT : bbt_pkg::BBT_RES_RD_ONES) && sec_serr_n)
		else $error("invalid read answered wrongly");

	csr_hit_c: cover property (@(posedge clock) disable iff (!rst_n) pri_claim && pri_csr);
	lut_event_c: cover property (@(posedge clock) disable iff (!rst_n) |evt_set ##1 !sec_inta_n);
	rd_abort_c: cover property (@(posedge clock) disable iff (!rst_n)
		sec_result == bbt_pkg::BBT_RES_TABORT);
	fwd_hit_c: cover property (@(posedge clock) disable iff (!rst_n) pri_claim && !pri_csr);

endmodule : bbt_bridge_xlat

// ### bbt_init_model.sv
/* initiator model for the primary and secondary decode ports.
 * assumes each task is entered 1 ns after a rising clock edge. */
`timescale 1ns/100ps
module bbt_init_model (
	input wire logic clock,
	output logic pri_valid,
	output logic [31:0] pri_addr,
	output logic sec_valid,
	output logic sec_write,
	output logic sec_xfer,
	output logic [31:0] sec_addr,
	output logic ans_p,
	output logic ans_s
);
	initial begin
		{pri_valid, sec_valid, sec_write, sec_xfer, ans_p, ans_s} = 6'h00;
		pri_addr = 32'h00000000;
		sec_addr = 32'h00000000;
	end
	task automatic pri_cyc(input logic [31:0] a);
		pri_valid = 1'b1;
		pri_addr = a;
		@(posedge clock);
		#1 pri_valid = 1'b0;
		// released address must not look held
		pri_addr = ~a;
		ans_p = 1'b1;
		@(posedge clock);
		#1 ans_p = 1'b0;
	endtask : pri_cyc
	task automatic sec_cyc(input logic [31:0] a, input logic w, input logic x);
		{sec_valid, sec_write, sec_xfer} = {1'b1, w, x};
		sec_addr = a;
		@(posedge clock);
		#1 {sec_valid, sec_write, sec_xfer} = {1'b0, ~w, 1'b0};
		sec_addr = ~a;
		ans_s = 1'b1;
		@(posedge clock);
		#1 ans_s = 1'b0;
	endtask : sec_cyc
endmodule : bbt_init_model

// ### bbt_bridge_xlat_bench.sv
/* self-checking bench for the window and lookup translation block.
 * assumes the model answers decodes one cycle after they are taken. */
`timescale 1ns/100ps
`define BBT_EQ(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module bbt_bridge_xlat_bench;
	logic clock = 1'b0, rst_n = 1'b0, rom_wr = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_sec;
	logic [7:0] rom_addr = 8'h00, cfg_addr = 8'h00;
	logic [31:0] rom_data = 32'h0, cfg_wdata = 32'h0, cfg_rdata, pri_addr, sec_addr, pri_xaddr;
	logic cfg_rvalid, pri_valid, pri_claim, pri_csr, pri_prefetch, sec_valid, sec_write;
	logic sec_xfer, sec_claim, sec_lut, sec_prefetch, sec_serr_n, sec_inta_n, ans_p, ans_s;
	logic [1:0] pri_win, sec_win;
	logic [31:0] sec_xaddr, rs = 32'h380e;
	bbt_pkg::bbt_res_e sec_result;
	logic [79:0] q[$];
	int err_total = 0, n_compared = 0;
	logic ce = 1'b1, pri_io = 1'b0, sec_io = 1'b0;
	always #12.5 clock = ~clock;
	bbt_bridge_xlat dut_u (.clock(clock), .rst_n(rst_n), .ce(ce), .rom_wr(rom_wr),
		.rom_addr(rom_addr), .rom_data(rom_data), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_sec(cfg_sec), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .pri_valid(pri_valid), .pri_io(pri_io), .pri_addr(pri_addr),
		.pri_claim(pri_claim), .pri_csr(pri_csr), .pri_win(pri_win),
		.pri_prefetch(pri_prefetch), .pri_xaddr(pri_xaddr), .sec_valid(sec_valid),
		.sec_io(sec_io), .sec_write(sec_write), .sec_xfer(sec_xfer), .sec_addr(sec_addr),
		.sec_claim(sec_claim), .sec_lut(sec_lut), .sec_win(sec_win),
		.sec_prefetch(sec_prefetch), .sec_xaddr(sec_xaddr), .sec_result(sec_result),
		.sec_serr_n(sec_serr_n), .sec_inta_n(sec_inta_n));
	bbt_init_model m (.clock(clock), .pri_valid(pri_valid), .pri_addr(pri_addr),
		.sec_valid(sec_valid), .sec_write(sec_write), .sec_xfer(sec_xfer),
		.sec_addr(sec_addr), .ans_p(ans_p), .ans_s(ans_s));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd
	task automatic exp(input logic [39:0] v, input logic [39:0] k = '1);
		q.push_back({k, v});
	endtask : exp
	task automatic check(input logic [39:0] g);
		logic [79:0] e;
		e = (q.size() > 0) ? q.pop_front() : 'x;
		`BBT_EQ(g & e[79:40], e[39:0])
	endtask : check
	always @(negedge clock) begin
		if (cfg_rvalid === 1'b1) check({8'h00, cfg_rdata});
		if (ans_p === 1'b1) check({3'h0, pri_claim, pri_csr, pri_win, pri_prefetch, pri_xaddr});
		if (ans_s === 1'b1) check({sec_claim, sec_lut, sec_prefetch, sec_result, sec_serr_n,
			sec_inta_n, sec_xaddr});
		if (ans_s === 1'b1) `BBT_EQ(sec_win, 2'h0)
	end
	task automatic acc(input logic r, input logic [7:0] a, input logic [31:0] d, input logic s);
		{cfg_rd, cfg_wr, cfg_addr, cfg_wdata, cfg_sec} = {r, ~r, a, d, s};
		if (r) exp({8'h00, d});
		@(posedge clock);
		#1 {cfg_rd, cfg_wr} = 2'b00;
		@(posedge clock);
		#1;
	endtask : acc
	task automatic rom(input logic [7:0] a, input logic [31:0] d);
		{rom_wr, rom_addr, rom_data} = {1'b1, a, d};
		@(posedge clock);
		#1 rom_wr = 1'b0;
		@(posedge clock);
		#1;
	endtask : rom
	task automatic complete_run();
		$display("counts: compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	initial begin
		#(25 * 3000);
		err_total++;
		complete_run();
	end
	initial begin
		logic [31:0] r;
		repeat (6) @(posedge clock);
		#1 rst_n = 1'b1;
		acc(1, 8'h40, 32'h0, 0);
		acc(1, 8'h50, 32'hffffffff, 1);
		acc(1, 8'h3c, 32'h0, 0);
		acc(0, 8'h84, 32'hffff0008, 0);
		acc(1, 8'h84, 32'h0, 1);
		// contiguous size mask, prefetchable memory
		rom(8'h84, 32'hffff0008);
		acc(1, 8'h84, 32'hffff0008, 1);
		acc(0, 8'ha4, 32'h12345678, 0);
		acc(1, 8'ha4, 32'h12340008, 0);
		acc(0, 8'hc4, 32'haabb0000, 1);
		// frozen clock enable drops the write
		ce = 1'b0;
		acc(0, 8'hc4, 32'h11110000, 1);
		ce = 1'b1;
		acc(1, 8'hc4, 32'haabb0000, 0);
		// 64-bit type on the third downstream memory window
		rom(8'h8c, 32'h00000004);
		rom(8'h98, 32'hffffffff);
		acc(0, 8'hb8, 32'h12345678, 0);
		acc(1, 8'hb8, 32'h12345678, 0);
		acc(1, 8'hac, 32'h00000004, 0);
		repeat (4) begin
			r = rnd();
			exp({3'h0, 1'b1, 1'b0, 2'h1, 1'b1, 32'haabb0000 | r[15:0]});
			m.pri_cyc(32'h12340000 | r[15:0]);
		end
		exp(40'h0, 40'h1000000000);
		m.pri_cyc(32'h12350000);
		// io cycle misses the memory window
		pri_io = 1'b1;
		exp(40'h0, 40'h1000000000);
		m.pri_cyc(32'h12340010);
		pri_io = 1'b0;
		acc(0, 8'ha8, 32'h40000000, 0);
		exp(40'h0, 40'h1000000000);
		m.pri_cyc(32'h40000010);
		acc(0, 8'ha0, 32'h55555678, 0);
		acc(1, 8'ha0, 32'h55555000, 0);
		exp({3'h0, 1'b1, 1'b1, 2'h0, 1'b0, 32'h0});
		m.pri_cyc(32'h55555abc);
		$display("test done: direct windows");
		acc(0, 8'h40, 32'h90, 1);
		acc(0, 8'hbc, 32'h00100000, 1);
		// every used entry written before lookup traffic, none rewritten in use
		acc(0, 8'h24, 32'h5, 1);
		acc(0, 8'h28, 32'hcafe0003, 1);
		acc(0, 8'h24, 32'h6, 0);
		acc(0, 8'h28, 32'h0, 0);
		acc(1, 8'h28, 32'h0, 1);
		acc(0, 8'h50, 32'h0, 1);
		exp({3'h7, bbt_pkg::BBT_RES_OK, 2'b10, 32'hcafe00fc});
		m.sec_cyc(32'h001005fc, 1, 1);
		exp({2'h3, 1'b0, bbt_pkg::BBT_RES_WR_ABORT, 2'b00, 32'h0}, 40'hdf00000000);
		m.sec_cyc(32'h00100600, 1, 1);
		acc(1, 8'h48, 32'h20, 1);
		acc(0, 8'h48, 32'h20, 1);
		exp({2'h3, 1'b0, bbt_pkg::BBT_RES_RD_ONES, 2'b11, 32'h0}, 40'hdf00000000);
		m.sec_cyc(32'h00100600, 0, 0);
		acc(0, 8'h40, 32'hb0, 1);
		exp({2'h3, 1'b0, bbt_pkg::BBT_RES_TABORT, 2'b11, 32'h0}, 40'hdf00000000);
		m.sec_cyc(32'h00100600, 0, 0);
		// 4KB pages move the index and offset split
		acc(0, 8'h40, 32'h94, 1);
		exp({3'h7, bbt_pkg::BBT_RES_OK, 2'b11, 32'hcafe0abc});
		m.sec_cyc(32'h00105abc, 0, 1);
		// io cycles never hit the lookup window
		sec_io = 1'b1;
		exp(40'h0, 40'hc000000000);
		m.sec_cyc(32'h00105abc, 0, 1);
		sec_io = 1'b0;
		$display("test done: lookup window");
		repeat (3) @(posedge clock);
		complete_run();
	end
endmodule : bbt_bridge_xlat_bench
